/* File: pms_pkg.sv */
package pms_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FREQ_W = 24;
   localparam int HIST_AW = 7;
   localparam int HIST_DEPTH = 128;
   localparam int NVM_WORDS = 4;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BW = 8'h04;
   localparam logic [7:0] OFS_HOLD = 8'h08;
   localparam logic [7:0] OFS_RAMP = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   localparam int CTRL_HARD_BIT = 0;
   localparam int CTRL_SOFT_BIT = 1;
   localparam int CTRL_FAST_BIT = 2;
   localparam int CTRL_RAMP_BIT = 3;
   localparam int CTRL_EXITBW_BIT = 4;
   localparam int CTRL_REFEXT_BIT = 5;
   localparam int BW_NORM_LSB = 0;
   localparam int BW_FAST_LSB = 4;
   localparam int BW_EXIT_LSB = 8;
   localparam int HOLD_WIN_LSB = 0;
   localparam int HOLD_DLY_LSB = 8;
   localparam int RAMP_RATE_LSB = 0;
   localparam int RAMP_PREDIV_LSB = 8;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_LOCK_BIT = 3;
   localparam int STAT_INIT_BIT = 4;
   localparam int STAT_HOLD_BIT = 5;

   // Bandwidth codes: 0 is the narrowest normal setting, 15 the widest.
   localparam logic [3:0] BW_CODE_MIN = 4'h0;
   localparam logic [3:0] BW_CODE_MAX = 4'hF;
   localparam logic [3:0] BW_FAST_MIN = 4'h8;
   localparam logic [2:0] WIN_LOG2_MAX = 3'h6;

   typedef enum logic [2:0] {
      PMS_INIT,
      PMS_FREERUN,
      PMS_ACQUIRE,
      PMS_LOCKED,
      PMS_AVERAGE,
      PMS_HOLDOVER,
      PMS_RAMP
   } pms_mode_e;

   typedef struct packed {
      logic fast_en;
      logic ramp_en;
      logic exit_bw_sel;
      logic ref_ext;
      logic [3:0] bw_norm;
      logic [3:0] bw_fast;
      logic [3:0] bw_exit;
      logic [2:0] win_log2;
      logic [5:0] delay;
      logic [5:0] ramp_rate;
      logic [1:0] prediv;
   } pms_cfg_s;

   localparam pms_cfg_s CFG_RESET = '0;

endpackage

/* File: pms_hist_mem.sv */
`timescale 1ns/100ps
module pms_hist_mem (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [pms_pkg::HIST_AW-1:0] waddr_i,
   input wire logic [pms_pkg::FREQ_W-1:0] wdata_i,
   input wire logic [pms_pkg::HIST_AW-1:0] raddr_i,
   output logic [pms_pkg::FREQ_W-1:0] rdata_o
);

   logic [pms_pkg::FREQ_W-1:0] mem [pms_pkg::HIST_DEPTH];

   // The array holds no reset so that it maps onto plain block memory.
   always_ff @(posedge clk_i)
   begin
      if (ce_i && wr_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule

/* File: pms_sequencer.sv */
`timescale 1ns/100ps
module pms_sequencer (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic HARD_RESET_N_I,
   input wire logic [pms_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [pms_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [pms_pkg::DATA_W-1:0] RDATA_O,
   output logic [1:0] NVM_ADDR_O,
   output logic NVM_RD_O,
   input wire logic [pms_pkg::DATA_W-1:0] NVM_DATA_I,
   input wire logic [3:0] IN_VALID_I,
   input wire logic SEL_VALID_I,
   input wire logic LOCK_DET_I,
   input wire logic HIST_TICK_I,
   input wire logic [pms_pkg::FREQ_W-1:0] FREQ_EST_I,
   output logic INIT_DONE_O,
   output logic CLK_OUT_EN_O,
   output logic LOCK_LOST_O,
   output logic [2:0] MODE_O,
   output logic [3:0] BW_CODE_O,
   output logic HOLD_ACTIVE_O,
   output logic [pms_pkg::FREQ_W-1:0] HOLD_FREQ_O,
   output logic [5:0] RAMP_RATE_O,
   output logic REF_EXT_O,
   output logic XTAL_CAP_EN_O,
   output logic [1:0] PREDIV_O
);

   function automatic pms_pkg::pms_cfg_s put_word(input pms_pkg::pms_cfg_s c,
                                                  input logic [1:0] idx,
                                                  input logic [pms_pkg::DATA_W-1:0] w);
      pms_pkg::pms_cfg_s r;
      r = c;
      case (idx)
         2'h0:
         begin
            r.fast_en = w[pms_pkg::CTRL_FAST_BIT];
            r.ramp_en = w[pms_pkg::CTRL_RAMP_BIT];
            r.exit_bw_sel = w[pms_pkg::CTRL_EXITBW_BIT];
            r.ref_ext = w[pms_pkg::CTRL_REFEXT_BIT];
         end
         2'h1:
         begin
            r.bw_norm = w[pms_pkg::BW_NORM_LSB +: 4];
            r.bw_fast = w[pms_pkg::BW_FAST_LSB +: 4];
            r.bw_exit = w[pms_pkg::BW_EXIT_LSB +: 4];
         end
         2'h2:
         begin
            r.win_log2 = w[pms_pkg::HOLD_WIN_LSB +: 3];
            r.delay = w[pms_pkg::HOLD_DLY_LSB +: 6];
         end
         default:
         begin
            r.ramp_rate = w[pms_pkg::RAMP_RATE_LSB +: 6];
            r.prediv = w[pms_pkg::RAMP_PREDIV_LSB +: 2];
         end
      endcase
      return r;
   endfunction

   function automatic logic [3:0] clamp_code(input logic [3:0] code, input logic [3:0] lo);
      return (code < lo) ? lo : code;
   endfunction

   logic rst_all;
   logic hard_pulse_reg;
   logic bus_open;
   pms_pkg::pms_mode_e mode_reg;
   pms_pkg::pms_mode_e mode_next;
   pms_pkg::pms_cfg_s pend_reg;
   pms_pkg::pms_cfg_s act_reg;
   logic [2:0] init_cnt_reg;
   logic [pms_pkg::DATA_W-1:0] rdata_reg;
   logic exit_reg;
   logic [pms_pkg::HIST_AW-1:0] wr_ptr_reg;
   logic [pms_pkg::HIST_AW-1:0] rd_addr;
   logic [pms_pkg::FREQ_W-1:0] hist_rdata;
   logic [7:0] avg_k_reg;
   logic [7:0] avg_len;
   logic [2:0] win_eff;
   logic avg_vld_reg;
   logic avg_done;
   logic [pms_pkg::FREQ_W+7:0] acc_reg;
   logic [pms_pkg::FREQ_W-1:0] freq_reg;
   logic [pms_pkg::FREQ_W-1:0] target_reg;
   logic [pms_pkg::FREQ_W-1:0] step;
   logic ramp_done;
   logic any_valid;

   // Hard reset is folded into the synchronous reset of every process.
   assign rst_all = SRST_I || !HARD_RESET_N_I || hard_pulse_reg;
   assign bus_open = (mode_reg != pms_pkg::PMS_INIT);
   assign any_valid = |IN_VALID_I;

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         hard_pulse_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         hard_pulse_reg <= bus_open && WR_I && (ADDR_I == pms_pkg::OFS_CTRL)
                           && WDATA_I[pms_pkg::CTRL_HARD_BIT];
      end
   end

   // Memory words are requested one per cycle and captured a cycle later.
   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         init_cnt_reg <= 3'h0;
      end
      else if (CE_I && mode_reg == pms_pkg::PMS_INIT)
      begin
         init_cnt_reg <= init_cnt_reg + 3'h1;
      end
   end

   assign NVM_RD_O = (mode_reg == pms_pkg::PMS_INIT) && (init_cnt_reg < 3'(pms_pkg::NVM_WORDS));
   assign NVM_ADDR_O = init_cnt_reg[1:0];

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         pend_reg <= pms_pkg::CFG_RESET;
         act_reg <= pms_pkg::CFG_RESET;
      end
      else if (CE_I)
      begin
         if (mode_reg == pms_pkg::PMS_INIT && init_cnt_reg != 3'h0)
         begin
            pend_reg <= put_word(pend_reg, 2'(init_cnt_reg - 3'h1), NVM_DATA_I);
            act_reg <= put_word(act_reg, 2'(init_cnt_reg - 3'h1), NVM_DATA_I);
         end
         else if (bus_open && WR_I)
         begin
            // Writes only stage values; the loop sees them after a soft reset.
            case (ADDR_I)
               pms_pkg::OFS_CTRL:
               begin
                  pend_reg <= put_word(pend_reg, 2'h0, WDATA_I);
                  if (WDATA_I[pms_pkg::CTRL_SOFT_BIT])
                  begin
                     act_reg <= put_word(pend_reg, 2'h0, WDATA_I);
                  end
               end
               pms_pkg::OFS_BW: pend_reg <= put_word(pend_reg, 2'h1, WDATA_I);
               pms_pkg::OFS_HOLD: pend_reg <= put_word(pend_reg, 2'h2, WDATA_I);
               pms_pkg::OFS_RAMP: pend_reg <= put_word(pend_reg, 2'h3, WDATA_I);
               default: pend_reg <= pend_reg;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         rdata_reg <= '0;
      end
      else if (CE_I)
      begin
         rdata_reg <= '0;
         if (bus_open && RD_I)
         begin
            case (ADDR_I)
               pms_pkg::OFS_CTRL:
               begin
                  rdata_reg[pms_pkg::CTRL_FAST_BIT] <= pend_reg.fast_en;
                  rdata_reg[pms_pkg::CTRL_RAMP_BIT] <= pend_reg.ramp_en;
                  rdata_reg[pms_pkg::CTRL_EXITBW_BIT] <= pend_reg.exit_bw_sel;
                  rdata_reg[pms_pkg::CTRL_REFEXT_BIT] <= pend_reg.ref_ext;
               end
               pms_pkg::OFS_BW:
               begin
                  rdata_reg[pms_pkg::BW_NORM_LSB +: 4] <= pend_reg.bw_norm;
                  rdata_reg[pms_pkg::BW_FAST_LSB +: 4] <= pend_reg.bw_fast;
                  rdata_reg[pms_pkg::BW_EXIT_LSB +: 4] <= pend_reg.bw_exit;
               end
               pms_pkg::OFS_HOLD:
               begin
                  rdata_reg[pms_pkg::HOLD_WIN_LSB +: 3] <= pend_reg.win_log2;
                  rdata_reg[pms_pkg::HOLD_DLY_LSB +: 6] <= pend_reg.delay;
               end
               pms_pkg::OFS_RAMP:
               begin
                  rdata_reg[pms_pkg::RAMP_RATE_LSB +: 6] <= pend_reg.ramp_rate;
                  rdata_reg[pms_pkg::RAMP_PREDIV_LSB +: 2] <= pend_reg.prediv;
               end
               pms_pkg::OFS_STATUS:
               begin
                  rdata_reg[pms_pkg::STAT_MODE_LSB +: 3] <= mode_reg;
                  rdata_reg[pms_pkg::STAT_LOCK_BIT] <= (mode_reg == pms_pkg::PMS_LOCKED);
                  rdata_reg[pms_pkg::STAT_INIT_BIT] <= 1'b1;
                  rdata_reg[pms_pkg::STAT_HOLD_BIT] <= HOLD_ACTIVE_O;
               end
               default: rdata_reg <= '0;
            endcase
         end
      end
   end

   assign RDATA_O = rdata_reg;

   // A window wider than the clamp would overlap itself in the history ring.
   assign win_eff = (act_reg.win_log2 > pms_pkg::WIN_LOG2_MAX) ? pms_pkg::WIN_LOG2_MAX
                                                              : act_reg.win_log2;
   assign avg_len = 8'h01 << win_eff;
   assign avg_done = (mode_reg == pms_pkg::PMS_AVERAGE) && (avg_k_reg == avg_len) && !avg_vld_reg;
   assign step = pms_pkg::FREQ_W'(act_reg.ramp_rate) + 24'h00_0001;
   assign ramp_done = (freq_reg == target_reg);

   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         pms_pkg::PMS_INIT:
            if (init_cnt_reg == 3'(pms_pkg::NVM_WORDS)) mode_next = pms_pkg::PMS_FREERUN;
         pms_pkg::PMS_FREERUN:
            if (any_valid) mode_next = pms_pkg::PMS_ACQUIRE;
         pms_pkg::PMS_ACQUIRE:
            if (LOCK_DET_I) mode_next = pms_pkg::PMS_LOCKED;
            else if (!any_valid) mode_next = pms_pkg::PMS_FREERUN;
         pms_pkg::PMS_LOCKED:
            if (!SEL_VALID_I && !any_valid) mode_next = pms_pkg::PMS_AVERAGE;
            else if (!LOCK_DET_I) mode_next = pms_pkg::PMS_ACQUIRE;
         pms_pkg::PMS_AVERAGE:
            if (avg_done) mode_next = pms_pkg::PMS_HOLDOVER;
         pms_pkg::PMS_HOLDOVER:
            if (any_valid)
               mode_next = act_reg.ramp_en ? pms_pkg::PMS_RAMP : pms_pkg::PMS_ACQUIRE;
         pms_pkg::PMS_RAMP:
            if (!any_valid) mode_next = pms_pkg::PMS_HOLDOVER;
            else if (ramp_done) mode_next = pms_pkg::PMS_ACQUIRE;
         default: mode_next = pms_pkg::PMS_INIT;
      endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         mode_reg <= pms_pkg::PMS_INIT;
      end
      else if (CE_I)
      begin
         mode_reg <= mode_next;
      end
   end

   // Remembers that the current acquisition follows an unramped holdover exit.
   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         exit_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         if (mode_reg == pms_pkg::PMS_HOLDOVER && mode_next == pms_pkg::PMS_ACQUIRE)
            exit_reg <= 1'b1;
         else if (mode_next != pms_pkg::PMS_ACQUIRE)
            exit_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         BW_CODE_O <= pms_pkg::BW_CODE_MIN;
      end
      else if (CE_I)
      begin
         if (mode_reg == pms_pkg::PMS_ACQUIRE && exit_reg && act_reg.exit_bw_sel)
            BW_CODE_O <= act_reg.bw_exit;
         else if (mode_reg == pms_pkg::PMS_ACQUIRE && !exit_reg && act_reg.fast_en)
            BW_CODE_O <= clamp_code(act_reg.bw_fast, pms_pkg::BW_FAST_MIN);
         else
            BW_CODE_O <= clamp_code(act_reg.bw_norm, pms_pkg::BW_CODE_MIN);
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         wr_ptr_reg <= '0;
      end
      else if (CE_I && mode_reg == pms_pkg::PMS_LOCKED && HIST_TICK_I)
      begin
         wr_ptr_reg <= wr_ptr_reg + 7'h01;
      end
   end

   // Newest usable sample sits delay entries behind the last written one.
   assign rd_addr = wr_ptr_reg - 7'h01 - 7'(act_reg.delay) - avg_k_reg[6:0];

   pms_hist_mem u_hist (
      .clk_i(CLK_I),
      .ce_i(CE_I),
      .wr_i(mode_reg == pms_pkg::PMS_LOCKED && HIST_TICK_I),
      .waddr_i(wr_ptr_reg),
      .wdata_i(FREQ_EST_I),
      .raddr_i(rd_addr),
      .rdata_o(hist_rdata)
   );

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         avg_k_reg <= 8'h00;
         avg_vld_reg <= 1'b0;
         acc_reg <= '0;
      end
      else if (CE_I)
      begin
         avg_vld_reg <= (mode_reg == pms_pkg::PMS_AVERAGE) && (avg_k_reg < avg_len);
         if (mode_reg != pms_pkg::PMS_AVERAGE)
         begin
            avg_k_reg <= 8'h00;
            acc_reg <= '0;
         end
         else
         begin
            if (avg_k_reg < avg_len)
               avg_k_reg <= avg_k_reg + 8'h01;
            if (avg_vld_reg)
               acc_reg <= acc_reg + {8'h00, hist_rdata};
         end
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (rst_all)
      begin
         freq_reg <= '0;
         target_reg <= '0;
      end
      else if (CE_I)
      begin
         if (avg_done)
            freq_reg <= pms_pkg::FREQ_W'(acc_reg >> win_eff);
         else if (mode_reg == pms_pkg::PMS_HOLDOVER && mode_next == pms_pkg::PMS_RAMP)
            target_reg <= FREQ_EST_I;
         else if (mode_reg == pms_pkg::PMS_RAMP && !ramp_done)
         begin
            // Fixed step per cycle keeps the slope linear; the last step is trimmed.
            if (target_reg > freq_reg)
               freq_reg <= (target_reg - freq_reg <= step) ? target_reg : freq_reg + step;
            else
               freq_reg <= (freq_reg - target_reg <= step) ? target_reg : freq_reg - step;
         end
      end
   end

   assign INIT_DONE_O = bus_open;
   assign CLK_OUT_EN_O = bus_open;
   assign LOCK_LOST_O = (mode_reg != pms_pkg::PMS_LOCKED);
   assign MODE_O = mode_reg;
   assign HOLD_ACTIVE_O = (mode_reg == pms_pkg::PMS_HOLDOVER) || (mode_reg == pms_pkg::PMS_RAMP);
   assign HOLD_FREQ_O = freq_reg;
   assign RAMP_RATE_O = act_reg.ramp_rate;
   assign REF_EXT_O = act_reg.ref_ext;
   assign XTAL_CAP_EN_O = !act_reg.ref_ext;
   assign PREDIV_O = act_reg.prediv;

endmodule

/* File: pms_nvm_model.sv */
`timescale 1ns/100ps
module pms_nvm_model #(
   parameter logic [31:0] W0 = 32'h0000_0024,
   parameter logic [31:0] W1 = 32'h0000_0593,
   parameter logic [31:0] W2 = 32'h0000_0001,
   parameter logic [31:0] W3 = 32'h0000_0200
) (
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic [1:0] addr_i,
   output logic [31:0] data_o
);
   logic [31:0] mem [4];
   assign mem[0] = W0;
   assign mem[1] = W1;
   assign mem[2] = W2;
   assign mem[3] = W3;
   // Data stand only in the cycle after a read; otherwise the bus flips so stale
   // words alternate between inverted and true on each cycle without a read.
   always @(posedge clk_i)
   begin
      if (rd_i)
         data_o <= mem[addr_i];
      else
         data_o <= ~data_o;
   end
   initial data_o = 32'h0000_0000;
endmodule

/* File: pms_sequencer_sva.sv */
`timescale 1ns/100ps
module pms_seq_sva (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic HARD_RESET_N_I,
   input wire logic [pms_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic RD_I,
   input wire logic [pms_pkg::DATA_W-1:0] RDATA_O,
   input wire logic [1:0] NVM_ADDR_O,
   input wire logic NVM_RD_O,
   input wire logic [3:0] IN_VALID_I,
   input wire logic SEL_VALID_I,
   input wire logic LOCK_DET_I,
   input wire logic INIT_DONE_O,
   input wire logic CLK_OUT_EN_O,
   input wire logic LOCK_LOST_O,
   input wire logic [2:0] MODE_O,
   input wire logic HOLD_ACTIVE_O,
   input wire logic REF_EXT_O,
   input wire logic XTAL_CAP_EN_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   logic rd_take;
   assign rd_take = RD_I && CE_I && INIT_DONE_O;
   a_lol_mode: assert property (LOCK_LOST_O == (MODE_O != 3'h3))
      else $error("lock lost flag disagrees with mode");
   a_clk_gate: assert property (CLK_OUT_EN_O == (MODE_O != 3'h0) && INIT_DONE_O == CLK_OUT_EN_O)
      else $error("clock enable wrong for mode");
   a_pin_reset: assert property (!HARD_RESET_N_I |=> MODE_O == 3'h0 && NVM_RD_O && NVM_ADDR_O == 2'h0)
      else $error("reset pin did not restart init");
   a_init_seq: assert property (!HARD_RESET_N_I ##1 (HARD_RESET_N_I && CE_I)[*5] |->
      MODE_O == 3'h0 ##1 MODE_O == 3'h1) else $error("init to freerun timing wrong");
   a_rd_idle: assert property (!$past(rd_take) |-> RDATA_O == '0)
      else $error("read data outside read cycle");
   a_status_rd: assert property ($past(rd_take && ADDR_I == pms_pkg::OFS_STATUS) |->
      RDATA_O[5:0] == {$past(HOLD_ACTIVE_O), $past(INIT_DONE_O), !$past(LOCK_LOST_O),
      $past(MODE_O)}) else $error("status read wrong");
   a_hold_flag: assert property (HOLD_ACTIVE_O == (MODE_O == 3'h5 || MODE_O == 3'h6))
      else $error("holdover flag wrong");
   a_xtal_cap: assert property (XTAL_CAP_EN_O == !REF_EXT_O)
      else $error("load caps on with external reference");
   a_acq_start: assert property (MODE_O == 3'h1 && CE_I && HARD_RESET_N_I && |IN_VALID_I |=>
      MODE_O == 3'h2) else $error("acquisition not started");
   a_lock_go: assert property (MODE_O == 3'h2 && CE_I && HARD_RESET_N_I && LOCK_DET_I &&
      |IN_VALID_I |=> MODE_O == 3'h3) else $error("lock not entered");
   a_hold_entry: assert property (MODE_O == 3'h3 && CE_I && LOCK_DET_I && !SEL_VALID_I &&
      HARD_RESET_N_I && IN_VALID_I == 4'h0 |=> MODE_O == 3'h4)
      else $error("holdover averaging not entered");
   a_hold_exit: assert property (MODE_O == 3'h5 && CE_I && HARD_RESET_N_I && |IN_VALID_I |=>
      MODE_O inside {3'h2, 3'h6}) else $error("holdover not left");
   c_locked: cover property (MODE_O == 3'h3);
   c_hold: cover property (MODE_O == 3'h5);
   c_ramp: cover property (MODE_O == 3'h6);
endmodule

/* File: pms_sequencer_tb_top.sv */
`timescale 1ns/100ps
module pms_sequencer_tb_top;
   logic clk = 0, srst = 1, ce = 1, hrst_n = 1, wr = 0, rd = 0, nvm_rd, init_done, clk_en;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, nvm_data, d;
   logic [1:0] nvm_addr, prediv;
   logic [3:0] in_valid = 4'h0, bw;
   logic sel_valid = 0, lock_det = 0, tick = 0, lock_lost_indicator, hold_act, ref_ext, cap_en;
   logic [23:0] freq = 24'h00_0000, hold_freq;
   logic [2:0] mode;
   logic [5:0] ramp_rate;
   int num_errors = 0, num_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   pms_sequencer dut (.CLK_I(clk), .SRST_I(srst), .CE_I(ce), .HARD_RESET_N_I(hrst_n),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .NVM_ADDR_O(nvm_addr), .NVM_RD_O(nvm_rd), .NVM_DATA_I(nvm_data), .IN_VALID_I(in_valid),
      .SEL_VALID_I(sel_valid), .LOCK_DET_I(lock_det), .HIST_TICK_I(tick), .FREQ_EST_I(freq),
      .INIT_DONE_O(init_done), .CLK_OUT_EN_O(clk_en), .LOCK_LOST_O(lock_lost_indicator), .MODE_O(mode),
      .BW_CODE_O(bw), .HOLD_ACTIVE_O(hold_act), .HOLD_FREQ_O(hold_freq),
      .RAMP_RATE_O(ramp_rate), .REF_EXT_O(ref_ext), .XTAL_CAP_EN_O(cap_en), .PREDIV_O(prediv));
   pms_nvm_model nvm (.clk_i(clk), .rd_i(nvm_rd), .addr_i(nvm_addr), .data_o(nvm_data));
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      #1 v = rdata;
   endtask
   task automatic wmode(input logic [2:0] m);
      for (int i = 0; i < 300 && mode !== m; i++)
      begin
         @(posedge clk);
         #1;
      end
      chk("mode", 32'(mode), 32'(m));
   endtask
   task automatic t_init;
      rd_reg(pms_pkg::OFS_STATUS, d);
      chk("early read", d, 32'h0000_0000);
      chk("clocks off", 32'(clk_en), 32'h0000_0000);
      wmode(3'h1);
      rd_reg(pms_pkg::OFS_CTRL, d);
      chk("ctrl", d, 32'h0000_0024);
      rd_reg(pms_pkg::OFS_BW, d);
      chk("bw", d, 32'h0000_0593);
      rd_reg(8'h20, d);
      chk("unmapped", d, 32'h0000_0000);
      chk("ext ref", 32'({ref_ext, cap_en, prediv}), 32'h0000_000A);
   endtask
   task automatic t_lock;
      in_valid <= 4'h1;
      sel_valid <= 1;
      wmode(3'h2);
      @(posedge clk);
      #1 chk("fast bw", 32'(bw), 32'h0000_0009);
      lock_det <= 1;
      wmode(3'h3);
      @(posedge clk);
      #1 chk("normal bw", 32'(bw), 32'h0000_0003);
      chk("lol", 32'(lock_lost_indicator), 32'h0000_0000);
      rd_reg(pms_pkg::OFS_STATUS, d);
      chk("status", d, 32'h0000_001B);
   endtask
   task automatic t_hold;
      for (int i = 1; i <= 8; i++)
      begin
         @(posedge clk);
         tick <= 1;
         freq <= 24'(i * 16);
         @(posedge clk);
         tick <= 0;
      end
      in_valid <= 4'h0;
      sel_valid <= 0;
      wmode(3'h4);
      lock_det <= 0;
      wmode(3'h5);
      chk("hold freq", 32'(hold_freq), 32'h0000_0078);
      chk("hold lol", 32'({hold_act, lock_lost_indicator}), 32'h0000_0003);
   endtask
   task automatic t_ramp;
      wr_reg(pms_pkg::OFS_RAMP, 32'h0000_0102);
      rd_reg(pms_pkg::OFS_RAMP, d);
      chk("ramp staged", d, 32'h0000_0102);
      chk("rate not active", 32'(ramp_rate), 32'h0000_0000);
      wr_reg(pms_pkg::OFS_CTRL, 32'h0000_002E);
      @(posedge clk);
      #1 chk("soft keeps mode", 32'(mode), 32'h0000_0005);
      chk("prediv", 32'(prediv), 32'h0000_0001);
      freq <= 24'h00_007D;
      in_valid <= 4'h2;
      wmode(3'h6);
      chk("ramp start", 32'(hold_freq), 32'h0000_0078);
      @(posedge clk);
      #1 chk("ramp step", 32'(hold_freq), 32'h0000_007B);
      chk("ramp rate", 32'(ramp_rate), 32'h0000_0002);
      wmode(3'h2);
      chk("ramp end", 32'(hold_freq), 32'h0000_007D);
   endtask
   task automatic t_exitbw;
      lock_det <= 1;
      wmode(3'h3);
      in_valid <= 4'h0;
      wmode(3'h5);
      lock_det <= 0;
      wr_reg(pms_pkg::OFS_BW, 32'h0000_0A24);
      wr_reg(pms_pkg::OFS_CTRL, 32'h0000_0036);
      in_valid <= 4'h4;
      wmode(3'h2);
      @(posedge clk);
      #1 chk("exit bw", 32'(bw), 32'h0000_000A);
   endtask
   task automatic t_hardbit;
      wr_reg(pms_pkg::OFS_STATUS, 32'h0000_0000);
      in_valid <= 4'h0;
      wr_reg(pms_pkg::OFS_CTRL, 32'h0000_0001);
      wmode(3'h0);
      wmode(3'h1);
      rd_reg(pms_pkg::OFS_CTRL, d);
      chk("reloaded ctrl", d, 32'h0000_0024);
   endtask
   task automatic t_pin;
      // The second pass stalls the clock enable to show that init waits for it.
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         hrst_n <= 0;
         @(posedge clk);
         hrst_n <= 1;
         ce <= k[0] ? 1'b0 : 1'b1;
         repeat (8) @(posedge clk);
         #1 chk("frozen init", 32'(init_done), 32'(k == 0));
         ce <= 1;
         wmode(3'h1);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // The ceiling sits far above the couple of hundred cycles the scenarios need.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 0;
      t_init();
      t_lock();
      t_hold();
      t_ramp();
      t_exitbw();
      t_hardbit();
      t_pin();
      wrap_up();
   end
endmodule
bind pms_sequencer pms_seq_sva chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
   .HARD_RESET_N_I(HARD_RESET_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .NVM_ADDR_O(NVM_ADDR_O), .NVM_RD_O(NVM_RD_O), .IN_VALID_I(IN_VALID_I),
   .SEL_VALID_I(SEL_VALID_I), .LOCK_DET_I(LOCK_DET_I), .INIT_DONE_O(INIT_DONE_O),
   .CLK_OUT_EN_O(CLK_OUT_EN_O), .LOCK_LOST_O(LOCK_LOST_O), .MODE_O(MODE_O),
   .HOLD_ACTIVE_O(HOLD_ACTIVE_O), .REF_EXT_O(REF_EXT_O), .XTAL_CAP_EN_O(XTAL_CAP_EN_O));
